// file: shared/vsmp_pkg.sv
package vsmp_pkg;
	// start code prefix and the slice value window
	localparam logic [23:0] VSMP_SC_PREFIX = 24'h000001;
	localparam logic [7:0] VSMP_SLICE_MIN = 8'h01;
	localparam logic [7:0] VSMP_SLICE_MAX = 8'hAF;
	localparam logic [7:0] VSMP_PIC_CODE = 8'h00;
	localparam logic [7:0] VSMP_VPOS_MAX = 8'hAF;
	// field lengths in bits, as last count index, except the code limit, which is a length
	localparam logic [3:0] VSMP_QUANT_LAST = 4'h4;
	localparam logic [3:0] VSMP_XBYTE_LAST = 4'h7;
	localparam logic [3:0] VSMP_VLC_MAXLEN = 4'hB;
	// address increment decoder results
	localparam logic [5:0] VSMP_MBA_NONE = 6'h00;
	localparam logic [5:0] VSMP_MBA_ESC = 6'h22;
	localparam logic [5:0] VSMP_MBA_STUFF = 6'h23;
	localparam logic [15:0] VSMP_ESC_STEP = 16'h0021;
	// macroblock geometry handed downstream
	localparam logic [4:0] VSMP_MB_PELS = 5'h10;
	localparam logic [2:0] VSMP_MB_BLOCKS = 3'h6;
	localparam logic [3:0] VSMP_BLK_EDGE = 4'h8;
	// reset values
	localparam logic [4:0] VSMP_QUANT_RST = 5'h01;
	localparam logic [15:0] VSMP_ADDR_RST = 16'hFFFF;

	typedef enum logic [2:0] {HUNT, QUANT, XFLAG, XBYTE, ADDR, STEP, BODY} vsmp_state_t;

	// one macroblock position record
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] row;
		logic [7:0] col;
		logic [4:0] quant;
		logic first;
	} vsmp_rec_t;
endpackage

// file: rtl/vsmp_parser.sv
`timescale 1ns/1ps
module vsmp_parser
	import vsmp_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	// serial coded bitstream, one bit per accepted cycle
	input wire logic bitIn,
	input wire logic bitValid,
	output logic bitReady,
	// picture width in macroblocks, from picture size decode
	input wire logic [7:0] mbWidth,
	// downstream finished the macroblock body, next header follows
	input wire logic nextMb,
	// quantizer replacement from a macroblock header
	input wire logic quantLoad,
	input wire logic [4:0] quantValue,
	// macroblock position records through the two-entry buffer
	output logic mbValid,
	input wire logic mbReady,
	output logic [15:0] mbAddr,
	output logic [7:0] mbRow,
	output logic [7:0] mbCol,
	output logic [4:0] mbQuant,
	output logic mbFirst,
	// slice events
	output logic sliceStart,
	output logic [7:0] sliceRow,
	output logic [4:0] curQuant,
	output logic parseError
);

	// whole state of the parser
	typedef struct packed {
		vsmp_state_t st;
		logic [31:0] sh;
		logic [2:0] bitPos;
		logic [3:0] cnt;
		logic [10:0] code;
		logic [15:0] escAcc;
		logic [4:0] quant;
		logic [15:0] prevAddr;
		logic [8:0] prevRow;
		logic [15:0] prevCol;
		logic first;
		logic [1:0] fill;
		vsmp_rec_t [1:0] fifo;
		logic outValid;
		logic readyR;
		logic sliceP;
		logic errP;
		logic [7:0] sRow;
	} vsmp_regs_t;

	vsmp_regs_t s; // registered state
	vsmp_regs_t next_s; // next state
	logic take; // a bit is accepted this cycle
	logic pop; // head record leaves the buffer
	logic scHit; // an aligned start code just completed
	logic [5:0] dec; // increment decoder result this cycle

	// serial decode of the address increment code; table is a
	// closed form per length so no lookup memory is needed
	function automatic logic [5:0] mba_decode(input logic [10:0] c, input logic [3:0] n);
		logic [5:0] r;
		r = VSMP_MBA_NONE;
		case (n)
			4'h1: if (c[0]) r = 6'h01;
			4'h3: if (c[2:0] >= 3'h2) r = 6'(6'h05 - {3'h0, c[2:0]});
			4'h4: if (c[3:0] >= 4'h2 && c[3:0] <= 4'h3) r = 6'(6'h07 - {2'h0, c[3:0]});
			4'h5: if (c[4:0] >= 5'h02 && c[4:0] <= 5'h03) r = 6'(6'h09 - {1'h0, c[4:0]});
			4'h7: if (c[6:0] >= 7'h06 && c[6:0] <= 7'h07) r = 6'(7'h0F - c[6:0]);
			4'h8: if (c[7:0] >= 8'h06 && c[7:0] <= 8'h0B) r = 6'(8'h15 - c[7:0]);
			4'hA: if (c[9:0] >= 10'h012 && c[9:0] <= 10'h017) r = 6'(10'h027 - c[9:0]);
			4'hB:
			begin
				if (c >= 11'h018 && c <= 11'h023)
					r = 6'(11'h039 - c);
				else if (c == 11'h008)
					r = VSMP_MBA_ESC;
				else if (c == 11'h00F)
					r = VSMP_MBA_STUFF;
			end
			default: r = VSMP_MBA_NONE;
		endcase
		return r;
	endfunction

	// all next-state logic
	always_comb
	begin
		logic [7:0] vpos;
		logic [3:0] len;
		logic [15:0] total;
		vsmp_rec_t rec;
		vpos = 8'h00;
		len = 4'h0;
		total = 16'h0000;
		rec = '0;
		next_s = s;
		next_s.sliceP = 1'b0;
		next_s.errP = 1'b0;
		dec = VSMP_MBA_NONE;
		scHit = 1'b0;
		pop = s.outValid && mbReady;
		take = s.readyR && bitValid;
		// drain the head first so a push this cycle sees the freed slot
		if (pop)
		begin
			next_s.fifo[0] = s.fifo[1];
			next_s.fifo[1] = '0;
			next_s.fill = s.fill - 2'h1;
		end
		if (quantLoad)
		begin
			if (quantValue != 5'h00)
				next_s.quant = quantValue;
			else
				next_s.errP = 1'b1; // zero scale is refused, old value kept
		end
		// body bits belong to downstream; resume header parse on its word
		// six 8x8 blocks downstream
		if (s.st == BODY && nextMb)
		begin
			next_s.st = ADDR;
			next_s.cnt = 4'h0;
			next_s.code = 11'h000;
			next_s.escAcc = 16'h0000;
		end
		if (s.st == STEP)
		begin
			if (mbWidth == 8'h00)
			begin
				next_s.errP = 1'b1; // no geometry, give up on this slice
				next_s.st = HUNT;
			end
			else if (s.prevCol >= {8'h00, mbWidth})
			begin
				next_s.prevCol = s.prevCol - {8'h00, mbWidth};
				next_s.prevRow = s.prevRow + 9'h001;
			end
			else if (next_s.fill != 2'h2)
			begin
				// buffer full stalls here, input stays held off
				// raster address recorded
				rec.addr = s.prevAddr;
				rec.row = s.prevRow[7:0];
				rec.col = s.prevCol[7:0];
				rec.quant = next_s.quant;
				rec.first = s.first;
				next_s.fifo[next_s.fill[0]] = rec;
				next_s.fill = next_s.fill + 2'h1;
				next_s.first = 1'b0;
				next_s.st = BODY;
			end
		end
		if (take)
		begin
			next_s.sh = {s.sh[30:0], bitIn};
			next_s.bitPos = s.bitPos + 3'h1;
			vpos = next_s.sh[7:0];
			// aligned 32-bit code; zeros just shift through
			scHit = (next_s.sh[31:8] == VSMP_SC_PREFIX) && (s.bitPos == 3'h7);
			if (scHit)
			begin
				if (vpos >= VSMP_SLICE_MIN && vpos <= VSMP_SLICE_MAX)
				begin
					// row is position minus one; no repeat check
					next_s.sRow = vpos - 8'h01;
					// previous address is end of row above
					next_s.prevAddr = 16'(next_s.sRow * mbWidth) - 16'h0001;
					next_s.prevRow = {1'b0, vpos} - 9'h002;
					next_s.prevCol = {8'h00, mbWidth} - 16'h0001;
					next_s.sliceP = 1'b1;
					next_s.first = 1'b1;
					next_s.cnt = 4'h0;
					next_s.st = QUANT;
				end
				else if (vpos == VSMP_PIC_CODE)
				begin
					// picture start sets address to -1
					next_s.prevAddr = VSMP_ADDR_RST;
					next_s.prevRow = 9'h1FF;
					next_s.prevCol = {8'h00, mbWidth} - 16'h0001;
					next_s.st = HUNT;
				end
				else
				begin
					next_s.errP = 1'b1;
					next_s.st = HUNT;
				end
			end
			else
			begin
				case (s.st)
					// hunting ignores everything but start codes
					HUNT: next_s.st = HUNT;
					QUANT:
					begin
						next_s.quant = {s.quant[3:0], bitIn};
						next_s.cnt = s.cnt + 4'h1;
						if (s.cnt == VSMP_QUANT_LAST)
						begin
							if ({s.quant[3:0], bitIn} == 5'h00)
							begin
								next_s.errP = 1'b1;
								next_s.st = HUNT;
							end
							else
								next_s.st = XFLAG;
						end
					end
					XFLAG:
					begin
						next_s.cnt = 4'h0;
						next_s.code = 11'h000;
						next_s.escAcc = 16'h0000;
						if (bitIn)
							next_s.st = XBYTE;
						else
							next_s.st = ADDR; // straight to macroblocks
					end
					XBYTE:
					begin
						// byte bits are dropped, only counted
						next_s.cnt = s.cnt + 4'h1;
						if (s.cnt == VSMP_XBYTE_LAST)
							next_s.st = XFLAG;
					end
					ADDR:
					begin
						len = s.cnt + 4'h1;
						next_s.code = {s.code[9:0], bitIn};
						next_s.cnt = len;
						dec = mba_decode(next_s.code, len);
						if (dec == VSMP_MBA_ESC)
						begin
							next_s.escAcc = s.escAcc + VSMP_ESC_STEP;
							next_s.cnt = 4'h0;
							next_s.code = 11'h000;
						end
						else if (dec == VSMP_MBA_STUFF)
						begin
							next_s.cnt = 4'h0;
							next_s.code = 11'h000;
						end
						else if (dec != VSMP_MBA_NONE)
						begin
							total = s.escAcc + {10'h000, dec};
							next_s.prevAddr = s.prevAddr + total;
							next_s.prevCol = s.prevCol + total;
							next_s.st = STEP;
						end
						else if (len == VSMP_VLC_MAXLEN)
						begin
							// all zeros is the run-up to the next start code
							next_s.errP = (next_s.code != 11'h000);
							next_s.st = HUNT;
						end
					end
					// body bits are dropped; a nextMb this cycle keeps its ADDR
					default: next_s.st = next_s.st;
				endcase
			end
		end
		// ready is registered, so it looks at the coming state
		next_s.readyR = (next_s.st != STEP);
		next_s.outValid = (next_s.fill != 2'h0);
	end

	// state register
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s <= '0;
			s.st <= HUNT;
			s.quant <= VSMP_QUANT_RST;
			s.prevAddr <= VSMP_ADDR_RST;
			s.prevRow <= 9'h1FF;
			s.readyR <= 1'b1;
		end
		else
			s <= next_s;
	end

	// outputs straight from state flops
	assign bitReady = s.readyR;
	assign mbValid = s.outValid;
	assign mbAddr = s.fifo[0].addr;
	assign mbRow = s.fifo[0].row;
	assign mbCol = s.fifo[0].col;
	assign mbQuant = s.fifo[0].quant;
	assign mbFirst = s.fifo[0].first;
	assign sliceStart = s.sliceP;
	assign sliceRow = s.sRow;
	assign curQuant = s.quant;
	assign parseError = s.errP;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// a completed slice code seen while bits flow
	sequence seqSliceCode;
		take && scHit && next_s.sh[7:0] >= VSMP_SLICE_MIN && next_s.sh[7:0] <= VSMP_SLICE_MAX;
	endsequence
	// the last quantizer bit is taken
	sequence seqQuantDone;
		take && !scHit && s.st == QUANT && s.cnt == VSMP_QUANT_LAST;
	endsequence

	a_slice_pulse: assert property (seqSliceCode |=> sliceStart && s.st == QUANT)
		else $error("slice code did not start a slice");
	a_slice_row: assert property (sliceStart |-> sliceRow == s.sh[7:0] - 8'h01)
		else $error("slice row is not position minus one");
	a_slice_align: assert property (sliceStart |->
		s.bitPos == 3'h0 && s.sh[31:8] == VSMP_SC_PREFIX)
		else $error("slice accepted off a byte boundary");
	a_slice_window: assert property (sliceStart |->
		s.sh[7:0] != 8'h00 && s.sh[7:0] <= VSMP_VPOS_MAX)
		else $error("slice code outside the window");
	a_quant_legal: assert property (seqQuantDone ##1 s.st == XFLAG |-> curQuant != 5'h00)
		else $error("zero quantizer let through");
	a_quant_zero_err: assert property (seqQuantDone ##0 ({s.quant[3:0], bitIn} == 5'h00) |=>
		parseError && s.st == HUNT)
		else $error("zero quantizer not flagged");
	a_escape_add: assert property (take && s.st == ADDR && dec == VSMP_MBA_ESC |=>
		s.escAcc == $past(s.escAcc) + VSMP_ESC_STEP)
		else $error("escape did not add 33");
	a_stuff_keep: assert property (take && s.st == ADDR && dec == VSMP_MBA_STUFF |=>
		$stable(s.prevAddr) && s.st == ADDR)
		else $error("stuffing changed the address");
	a_col_range: assert property (mbValid |-> mbWidth == 8'h00 || mbCol < mbWidth)
		else $error("column not below width");
	a_addr_map: assert property (mbValid && $stable(mbWidth) |->
		mbAddr == 16'(mbRow * mbWidth) + {8'h00, mbCol})
		else $error("address does not match row and column");
	a_step_stall: assert property (s.st == STEP |-> !bitReady ##1 1'b1)
		else $error("input accepted during address step");
endmodule

// file: verification/vsmp_bit_source.sv
`timescale 1ns/1ps
module vsmp_bit_source
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic slow,
	input wire logic bitReady,
	output logic bitIn,
	output logic bitValid
);
	// pending stream bits, oldest first
	logic q[$];
	// a bit was taken at the last rising edge
	logic took;

	initial
	begin
		bitIn = 1'b0;
		bitValid = 1'b0;
		took = 1'b0;
	end

	task put(input logic [31:0] v, input int n);
		for (int i = n - 1; i >= 0; i--)
			q.push_back(v[i]);
	endtask

	// note the handshake as the parser samples it
	always @(posedge clk)
		took <= bitValid && bitReady && arst_n;

	// a bit stands until taken; slow mode idles one cycle after each take
	// an idle line toggles so a stale bit is never mistaken for data
	always @(negedge clk)
	begin
		if (took)
			q.delete(0);
		if (q.size() > 0 && !(took && slow))
		begin
			bitValid <= 1'b1;
			bitIn <= q[0];
		end
		else
		begin
			bitValid <= 1'b0;
			bitIn <= ~bitIn;
		end
	end
endmodule

// file: verification/video_slice_macroblock_parser_test.sv
`timescale 1ns/1ps
module video_slice_macroblock_parser_test;
	import vsmp_pkg::*;
	logic clk, arst_n, bitIn, bitValid, bitReady, nextMb, quantLoad, slow;
	logic [7:0] mbWidth, mbRow, mbCol, sliceRow;
	logic [4:0] quantValue, mbQuant, curQuant;
	logic mbValid, mbReady, mbFirst, sliceStart, parseError;
	logic [15:0] mbAddr;
	// verdict counters and event tallies
	int nErrors, nChecks, nSlice, nFault, nb;
	// records seen leaving the buffer
	vsmp_rec_t recs[$];

	vsmp_bit_source u_src (.clk(clk), .arst_n(arst_n), .slow(slow), .bitReady(bitReady),
		.bitIn(bitIn), .bitValid(bitValid));
	vsmp_parser u_dut (.clk(clk), .arst_n(arst_n), .bitIn(bitIn), .bitValid(bitValid),
		.bitReady(bitReady), .mbWidth(mbWidth), .nextMb(nextMb), .quantLoad(quantLoad),
		.quantValue(quantValue), .mbValid(mbValid), .mbReady(mbReady), .mbAddr(mbAddr),
		.mbRow(mbRow), .mbCol(mbCol), .mbQuant(mbQuant), .mbFirst(mbFirst),
		.sliceStart(sliceStart), .sliceRow(sliceRow), .curQuant(curQuant),
		.parseError(parseError));

	// free running clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// pulses are counted here since they stand one cycle only
	always @(posedge clk)
	begin
		if (sliceStart === 1'b1)
			nSlice++;
		if (parseError === 1'b1)
			nFault++;
		if (mbValid === 1'b1 && mbReady === 1'b1)
			recs.push_back({mbAddr, mbRow, mbCol, mbQuant, mbFirst});
	end

	task conclude;
		$display("checks %0d mismatches %0d", nChecks, nErrors);
		if (nErrors == 0 && nChecks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task check(input logic [39:0] seen, input logic [39:0] exp);
		nChecks++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("unexpected at %0t ns: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task send(input logic [31:0] v, input int n);
		u_src.put(v, n);
		nb += n;
	endtask

	// zero fill to a byte boundary plus one zero byte
	task code(input logic [7:0] pos);
		send(32'h0, 8 + (8 - nb % 8) % 8);
		send({24'h000001, pos}, 32);
	endtask

	// slice header without extra bytes
	task hdr(input logic [7:0] pos, input logic [4:0] qs);
		code(pos);
		send(qs, 5);
		send(1'b0, 1);
	endtask

	// bounded wait for the source to empty, then let the parser settle
	task drain;
		for (int i = 0; i < 3000 && u_src.q.size() > 0; i++)
			@(negedge clk);
		repeat (10) @(negedge clk);
	endtask

	task pulse_next;
		nextMb = 1'b1;
		@(negedge clk);
		nextMb = 1'b0;
	endtask

	task load_quant(input logic [4:0] v);
		quantLoad = 1'b1;
		quantValue = v;
		@(negedge clk);
		quantLoad = 1'b0;
	endtask

	task clr;
		nSlice = 0;
		nFault = 0;
		recs.delete();
	endtask

	task t_basic;
		clr();
		hdr(8'h0A, 5'h05);
		send(7'b0000111, 7);
		drain();
		check(nSlice, 1);
		check(sliceRow, 8'h09);
		check(curQuant, 5'h05);
		check(recs[0], {16'h0097, 8'h09, 8'h07, 5'h05, 1'h1});
		load_quant(5'h07);
		check(curQuant, 5'h07);
		pulse_next();
		send(1'b1, 1);
		drain();
		check(recs[1], {16'h0098, 8'h09, 8'h08, 5'h07, 1'h0});
		$display("test basic done");
	endtask

	task t_escape;
		clr();
		slow = 1'b1;
		code(8'h01);
		send(5'h1F, 5);
		send({1'b1, 8'hA5, 1'b1, 8'h3C, 1'b0}, 19);
		send(11'h00F, 11);
		send(11'h008, 11);
		send(5'h02, 5);
		drain();
		check(sliceRow, 8'h00);
		check(recs[0], {16'h0027, 8'h02, 8'h07, 5'h1F, 1'h1});
		pulse_next();
		hdr(8'h01, 5'h03);
		send(1'b1, 1);
		drain();
		check(nSlice, 2);
		check(nFault, 0);
		check(recs[1], {16'h0000, 8'h00, 8'h00, 5'h03, 1'h1});
		slow = 1'b0;
		$display("test escape done");
	endtask

	task t_errors;
		clr();
		hdr(8'hAF, 5'h02);
		send(1'b1, 1);
		drain();
		check(sliceRow, 8'hAE);
		check(recs[0], {16'h0AE0, 8'hAE, 8'h00, 5'h02, 1'h1});
		code(8'hB0);
		drain();
		check(nFault, 1);
		hdr(8'h05, 5'h00);
		drain();
		check(nFault, 2);
		hdr(8'h05, 5'h04);
		send(1'b1, 1);
		drain();
		check(recs[1], {16'h0040, 8'h04, 8'h00, 5'h04, 1'h1});
		load_quant(5'h00);
		@(negedge clk);
		check(nFault, 3);
		check(curQuant, 5'h04);
		// a picture start code is no fault
		code(8'h00);
		drain();
		check(nFault, 3);
		$display("test errors done");
	endtask

	// three records against two buffer entries with the receiver stalled
	task t_stall;
		clr();
		mbWidth = 8'h04;
		mbReady = 1'b0;
		hdr(8'h02, 5'h01);
		send(1'b1, 1);
		drain();
		pulse_next();
		send(1'b1, 1);
		drain();
		pulse_next();
		send(1'b1, 1);
		drain();
		check(bitReady, 1'b0);
		check(mbValid, 1'b1);
		mbReady = 1'b1;
		drain();
		check(recs.size(), 3);
		check(recs[0].addr, 16'h0004);
		check(recs[2], {16'h0006, 8'h01, 8'h02, 5'h01, 1'h0});
		$display("test stall done");
	endtask

	// main sequence
	initial
	begin
		arst_n = 1'b0;
		nextMb = 1'b0;
		quantLoad = 1'b0;
		quantValue = 5'h00;
		mbWidth = 8'h10;
		mbReady = 1'b1;
		slow = 1'b0;
		nb = 0;
		nErrors = 0;
		nChecks = 0;
		clr();
		repeat (6) @(negedge clk);
		arst_n = 1'b1;
		t_basic();
		t_escape();
		t_errors();
		t_stall();
		conclude();
	end

	// watchdog, well beyond the several hundred cycles the tests take
	initial
	begin
		repeat (50000) @(posedge clk);
		nErrors++;
		conclude();
	end
endmodule
